// file: verilog/sddc_pkg.sv
// shared constants and carrier types of the segment descriptor decode and check block
package sddc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_DESC_LO = 8'h00;  // descriptor low word
  localparam logic [7:0] ADDR_DESC_HI = 8'h04;  // descriptor high word
  localparam logic [7:0] ADDR_CTRL    = 8'h08;  // privilege, table source, load commands
  localparam logic [7:0] ADDR_OFFSET  = 8'h0C;  // offset to be checked
  localparam logic [7:0] ADDR_CHECK   = 8'h10;  // access kind, a write starts a check
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // decoded fields and check result
  localparam logic [7:0] ADDR_BASE    = 8'h18;  // decoded base
  localparam logic [7:0] ADDR_LIMIT   = 8'h1C;  // effective limit
  // high word field positions
  localparam int HI_ACC_LSB = 8;   // access rights byte
  localparam int HI_LIM_LSB = 16;  // limit 19..16
  localparam int HI_OPSIZE  = 22;  // operand size / stack width bit
  localparam int HI_GRAN    = 23;  // size unit bit
  localparam int HI_BASEH   = 24;  // base 31..24
  // access rights bit positions
  localparam int AR_PRESENT = 7;
  localparam int AR_PRIV    = 5;
  localparam int AR_KIND    = 4;
  localparam int AR_CLASS   = 3;
  localparam int AR_DIR     = 2;
  localparam int AR_PERM    = 1;
  localparam int AR_TOUCHED = 0;
  // control register bit positions
  localparam int CTRL_PRIV   = 0;  // bits 1..0 current_privilege
  localparam int CTRL_GLOBAL = 2;  // descriptor fetched from global_table
  localparam int CTRL_LOAD   = 3;  // segment register load, self clearing
  localparam int CTRL_TEST   = 4;  // selector test, self clearing
  // status register bit positions
  localparam int ST_PRESENT = 0;
  localparam int ST_KIND    = 1;
  localparam int ST_CODE    = 2;
  localparam int ST_LEGACY  = 3;
  localparam int ST_LOCAL   = 4;
  localparam int ST_OPSZ32  = 5;
  localparam int ST_STK32   = 6;
  localparam int ST_BAD     = 7;
  localparam int ST_FAULT   = 8;
  localparam int ST_DONE    = 9;
  localparam int ST_PRIV    = 10;  // bits 11..10
  localparam int ST_VECTOR  = 16;  // bits 23..16
  // constant values
  localparam logic [3:0]  SYS_TYPE_LOCAL = 4'h2;          // local_table descriptor type
  localparam logic [7:0]  VEC_NOT_PRESENT = 8'h0B;        // not-present fault
  localparam logic [7:0]  VEC_PROTECTION  = 8'h0D;        // protection fault
  localparam logic [31:0] STACK_TOP_32 = 32'hFFFFFFFF;    // wide stack pointer bound
  localparam logic [31:0] STACK_TOP_16 = 32'h0000FFFF;    // narrow stack pointer bound
  localparam logic [11:0] PAGE_FILL = 12'hFFF;            // low bits of a page-granular limit
  localparam logic [31:0] RESET_WORD = 32'h00000000;      // value of every register after reset except status, which reads 32'h00000088
  // access kinds written to the check register
  typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC, ACC_STACK} sddc_acc_t;
  // decoded view of one descriptor
  typedef struct packed {
    logic        present;
    logic [1:0]  descriptor_privilege;
    logic        kind;        // code/data (1) or system (0)
    logic        isCode;
    logic        growDown;
    logic        writeOk;
    logic        readOk;
    logic        conforming;
    logic        opSize32;
    logic        stack32;
    logic        legacy;
    logic        localTable;
    logic        badDesc;
    logic [31:0] base;
    logic [31:0] limit;
  } sddc_dec_t;
endpackage

// file: verilog/sddc_field_decode.sv
// field decoder that splits a descriptor into its attributes
`timescale 1ns/100ps
`default_nettype none
module sddc_field_decode (
  input  wire logic        [31:0] descLo,      // limit 15..0, base 15..0
  input  wire logic        [31:0] descHi,      // upper descriptor word
  input  wire logic               fromGlobal,  // descriptor came from global_table
  output var sddc_pkg::sddc_dec_t dec          // decoded attributes
);
  logic [7:0]  acc;     // access rights byte
  logic [19:0] lim20;   // raw 20-bit limit
  logic [31:0] rawBase; // base before presence gating
  logic [31:0] rawLim;  // limit before presence gating
  logic        sysDesc; // system or gate descriptor

  // purely combinational; the main block registers whatever leaves it
  always_comb begin
    acc   = descHi[sddc_pkg::HI_ACC_LSB +: 8];
    lim20 = {descHi[sddc_pkg::HI_LIM_LSB +: 4], descLo[15:0]};
    sysDesc = ~acc[sddc_pkg::AR_KIND];
    dec = '0;
    dec.present    = acc[sddc_pkg::AR_PRESENT];
    dec.descriptor_privilege        = acc[sddc_pkg::AR_PRIV +: 2];
    dec.kind       = acc[sddc_pkg::AR_KIND];
    dec.isCode     = dec.kind & acc[sddc_pkg::AR_CLASS];
    dec.growDown   = dec.kind & ~dec.isCode & acc[sddc_pkg::AR_DIR];
    dec.writeOk    = dec.kind & ~dec.isCode & acc[sddc_pkg::AR_PERM];
    dec.readOk     = ~dec.isCode | acc[sddc_pkg::AR_PERM];
    dec.conforming = dec.isCode & acc[sddc_pkg::AR_DIR];
    // operand size only means something in a code descriptor
    dec.opSize32   = dec.isCode & descHi[sddc_pkg::HI_OPSIZE];
    dec.stack32    = dec.kind & ~dec.isCode & descHi[sddc_pkg::HI_OPSIZE];
    // legacy system format: upper half word all zero
    dec.legacy     = sysDesc & (descHi[31:16] == 16'h0000);
    dec.localTable = sysDesc & (acc[3:0] == sddc_pkg::SYS_TYPE_LOCAL);
    // local_table descriptor outside global_table, or a system kind not handled here
    dec.badDesc    = sysDesc & (~dec.localTable | ~fromGlobal);
    if (dec.legacy) begin
      rawBase = {8'h00, descHi[7:0], descLo[31:16]};
      rawLim  = {16'h0000, descLo[15:0]};
    end else begin
      rawBase = {descHi[sddc_pkg::HI_BASEH +: 8], descHi[7:0], descLo[31:16]};
      if (descHi[sddc_pkg::HI_GRAN])
        rawLim = {lim20, sddc_pkg::PAGE_FILL};
      else
        rawLim = {12'h000, lim20};
    end
    // an absent segment exposes no base and no limit
    dec.base  = dec.present ? rawBase : 32'h00000000;
    dec.limit = dec.present ? rawLim  : 32'h00000000;
  end
endmodule // sddc_field_decode
`default_nettype wire

// file: verilog/sddc_check_top.sv
// apb-attached segment descriptor decoder and access checker
//
// Contract
// - size unit bit chooses byte or page limit
// - not resident: segment unmapped, base/limit unused
// - privilege field feeds privilege tests
// - kind bit: code/data versus system
// - class bit: data or code segment
// - growth_direction sets legal offset side
// - data write needs write permission
// - code read needs read permission
// - writes through code segments always refused
// - conforming code needs current privilege >= descriptor
// - touched flag set on load or test
// - code operand size bit picks 32/16 bits
// - operand size ignored outside code descriptors
// - stack width flag picks pointer bound
// - zero upper half: legacy system format
// - local_table type ignores privilege field
// - local_table descriptor only from global_table
// - not resident access raises not-present fault; an unusable system descriptor raises protection fault instead
`timescale 1ns/100ps
`default_nettype none
module sddc_check_top (
  input  wire logic        clk,      // core clock, 200 MHz
  input  wire logic        sys_rst,  // synchronous reset, active high
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic             pready,   // apb ready
  output logic      [31:0] prdata,   // apb read data, registered
  output logic             pslverr   // apb error for unmapped address
);
  // complete state of the block
  typedef struct packed {
    logic [31:0] descLo;     // descriptor low word
    logic [31:0] descHi;     // descriptor high word, touched flag lives here
    logic [1:0]  curPriv;    // current_privilege
    logic        fromGlobal; // descriptor source table
    logic [31:0] offset;     // offset under test
    logic [1:0]  accKind;    // last checked access kind
    logic        fault;      // last check failed
    logic [7:0]  vector;     // fault vector of the last check
    logic        done;       // a check has run since reset
    logic [31:0] rdData;     // read data captured in setup phase
    logic        slvErr;     // error answer for the access phase
  } sddc_state_t;

  sddc_state_t         st_r;    // registered state
  sddc_state_t         st_nxt;  // next state
  sddc_pkg::sddc_dec_t dec;     // decoded descriptor
  logic                setup;   // apb setup phase
  logic                wrAcc;   // apb write taken this edge
  logic                mapped;  // address hits a register
  logic                chkFault;// fault outcome of a new check
  logic [7:0]          chkVec;  // vector outcome of a new check
  logic [31:0]         status;  // assembled status word
  sddc_pkg::sddc_acc_t newKind; // access kind of a new check

  // field decode of the stored descriptor
  sddc_field_decode u_dec (
    .descLo     (st_r.descLo),
    .descHi     (st_r.descHi),
    .fromGlobal (st_r.fromGlobal),
    .dec        (dec)
  );

  // bus phase decode; the slave never inserts wait states
  always_comb begin
    setup  = psel & ~penable;
    wrAcc  = psel & penable & pwrite;
    pready = 1'b1;
    case (paddr)
      sddc_pkg::ADDR_DESC_LO, sddc_pkg::ADDR_DESC_HI, sddc_pkg::ADDR_CTRL,
      sddc_pkg::ADDR_OFFSET, sddc_pkg::ADDR_CHECK, sddc_pkg::ADDR_STATUS,
      sddc_pkg::ADDR_BASE, sddc_pkg::ADDR_LIMIT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // access check of a new request, judged on the stored descriptor and offset
  always_comb begin
    newKind  = sddc_pkg::sddc_acc_t'(pwdata[1:0]);
    chkFault = 1'b0;
    chkVec   = 8'h00;
    if (!dec.present && dec.kind) begin
      // an absent code or data segment is refused before anything else is looked at
      chkFault = 1'b1;
      chkVec   = sddc_pkg::VEC_NOT_PRESENT;
    end else if (!dec.kind) begin
      // system descriptors: only a local_table one from global_table is usable,
      // and its privilege field is not consulted
      if (dec.badDesc) begin
        chkFault = 1'b1;
        chkVec   = sddc_pkg::VEC_PROTECTION;
      end else if (!dec.present) begin
        chkFault = 1'b1;
        chkVec   = sddc_pkg::VEC_NOT_PRESENT;
      end else if (st_r.offset > dec.limit) begin
        chkFault = 1'b1;
        chkVec   = sddc_pkg::VEC_PROTECTION;
      end
    end else if (dec.isCode) begin
      case (newKind)
        sddc_pkg::ACC_WRITE,
        sddc_pkg::ACC_STACK: chkFault = 1'b1;
        sddc_pkg::ACC_READ:  chkFault = ~dec.readOk;
        sddc_pkg::ACC_EXEC: begin
          // conforming code runs at equal or lesser privilege only
          if (dec.conforming)
            chkFault = (st_r.curPriv < dec.descriptor_privilege);
          else
            chkFault = 1'b0;
        end
        default: chkFault = 1'b1;
      endcase
      // a code offset is always expand-up against the limit
      if (st_r.offset > dec.limit)
        chkFault = 1'b1;
      chkVec = chkFault ? sddc_pkg::VEC_PROTECTION : 8'h00;
    end else begin
      // data and stack segments
      case (newKind)
        sddc_pkg::ACC_WRITE,
        sddc_pkg::ACC_STACK: chkFault = ~dec.writeOk;
        sddc_pkg::ACC_READ:  chkFault = 1'b0;
        sddc_pkg::ACC_EXEC:  chkFault = 1'b1;
        default:             chkFault = 1'b1;
      endcase
      // data is reached from a level no less privileged than its own
      if (st_r.curPriv > dec.descriptor_privilege)
        chkFault = 1'b1;
      if (dec.growDown) begin
        // expand-down: legal offsets lie above the limit and under the pointer top
        if (st_r.offset <= dec.limit)
          chkFault = 1'b1;
        if (dec.stack32 ? (st_r.offset > sddc_pkg::STACK_TOP_32)
                        : (st_r.offset > sddc_pkg::STACK_TOP_16))
          chkFault = 1'b1;
      end else if (st_r.offset > dec.limit) begin
        chkFault = 1'b1;
      end
      chkVec = chkFault ? sddc_pkg::VEC_PROTECTION : 8'h00;
    end
  end

  // status word assembled from the live decode and the last check
  always_comb begin
    status = 32'h00000000;
    status[sddc_pkg::ST_PRESENT] = dec.present;
    status[sddc_pkg::ST_KIND]    = dec.kind;
    status[sddc_pkg::ST_CODE]    = dec.isCode;
    status[sddc_pkg::ST_LEGACY]  = dec.legacy;
    status[sddc_pkg::ST_LOCAL]   = dec.localTable;
    status[sddc_pkg::ST_OPSZ32]  = dec.opSize32;
    status[sddc_pkg::ST_STK32]   = dec.stack32;
    status[sddc_pkg::ST_BAD]     = dec.badDesc;
    status[sddc_pkg::ST_FAULT]   = st_r.fault;
    status[sddc_pkg::ST_DONE]    = st_r.done;
    // privilege field is meaningless for a local_table descriptor
    status[sddc_pkg::ST_PRIV +: 2] = dec.localTable ? 2'b00 : dec.descriptor_privilege;
    status[sddc_pkg::ST_VECTOR +: 8] = st_r.vector;
  end

  // next state: register writes, commands, read data capture
  always_comb begin
    st_nxt = st_r;
    // read data and error are prepared in the setup phase so that
    // the access phase answers straight from flip-flops
    if (setup) begin
      st_nxt.slvErr = ~mapped;
      case (paddr)
        sddc_pkg::ADDR_DESC_LO: st_nxt.rdData = st_r.descLo;
        sddc_pkg::ADDR_DESC_HI: st_nxt.rdData = st_r.descHi;
        sddc_pkg::ADDR_CTRL:
          st_nxt.rdData = {29'h0, st_r.fromGlobal, st_r.curPriv};
        sddc_pkg::ADDR_OFFSET:  st_nxt.rdData = st_r.offset;
        sddc_pkg::ADDR_CHECK:   st_nxt.rdData = {30'h0, st_r.accKind};
        sddc_pkg::ADDR_STATUS:  st_nxt.rdData = status;
        sddc_pkg::ADDR_BASE:    st_nxt.rdData = dec.base;
        sddc_pkg::ADDR_LIMIT:   st_nxt.rdData = dec.limit;
        default:                st_nxt.rdData = 32'h00000000;
      endcase
    end
    // writes take effect at the access-phase edge; unmapped ones are dropped
    if (wrAcc) begin
      case (paddr)
        sddc_pkg::ADDR_DESC_LO: st_nxt.descLo = pwdata;
        sddc_pkg::ADDR_DESC_HI: st_nxt.descHi = pwdata;
        sddc_pkg::ADDR_CTRL: begin
          st_nxt.curPriv    = pwdata[sddc_pkg::CTRL_PRIV +: 2];
          st_nxt.fromGlobal = pwdata[sddc_pkg::CTRL_GLOBAL];
          // a load or selector test marks a code/data descriptor as touched
          if ((pwdata[sddc_pkg::CTRL_LOAD] | pwdata[sddc_pkg::CTRL_TEST]) && dec.kind)
            st_nxt.descHi[sddc_pkg::HI_ACC_LSB + sddc_pkg::AR_TOUCHED] = 1'b1;
        end
        sddc_pkg::ADDR_OFFSET: st_nxt.offset = pwdata;
        sddc_pkg::ADDR_CHECK: begin
          st_nxt.accKind = pwdata[1:0];
          st_nxt.fault   = chkFault;
          st_nxt.vector  = chkVec;
          st_nxt.done    = 1'b1;
        end
        default: st_nxt.done = st_r.done;
      endcase
    end
  end

  // single state register; every flop resets to a constant
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus answer straight from flip-flops
  always_comb begin
    prdata  = st_r.rdData;
    pslverr = psel & penable & st_r.slvErr;
  end
endmodule // sddc_check_top
`default_nettype wire

// file: testbench/sddc_check_chk.sv
// assertion checker on the apb ports of the descriptor decoder
`timescale 1ns/100ps
`default_nettype none
module sddc_check_chk (
  input wire logic        clk,      // core clock
  input wire logic        sys_rst,  // synchronous reset
  input wire logic        psel,     // apb select
  input wire logic        penable,  // apb access phase
  input wire logic        pwrite,   // apb direction
  input wire logic [7:0]  paddr,    // apb byte address
  input wire logic [31:0] pwdata,   // apb write data
  input wire logic        pready,   // apb ready
  input wire logic [31:0] prdata,   // apb read data
  input wire logic        pslverr   // apb error
);
  logic [31:0] loSh_r;  // shadow of the descriptor low word
  logic [31:0] hiSh_r;  // shadow of the descriptor high word
  logic        acRd;    // access phase of a read
  logic        stRd;    // access phase of a status read
  logic [31:0] limSh;   // effective limit from the shadow
  // shadows follow completed writes; touched updates are not mirrored, no check needs them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loSh_r <= 32'h00000000;
      hiSh_r <= 32'h00000000;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == sddc_pkg::ADDR_DESC_LO) loSh_r <= pwdata;
      if (paddr == sddc_pkg::ADDR_DESC_HI) hiSh_r <= pwdata;
    end
  end
  // read qualifiers and limit scaling
  always_comb begin
    acRd  = psel && penable && !pwrite;
    stRd  = acRd && paddr == sddc_pkg::ADDR_STATUS;
    limSh = hiSh_r[23] ? {hiSh_r[19:16], loSh_r[15:0], 12'hFFF}
                       : {12'h000, hiSh_r[19:16], loSh_r[15:0]};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_READY: assert property (psel && penable |-> pready) else $error("no ready in access");
  AST_RESET_QUIET: assert property ($fell(sys_rst) |-> prdata == 32'h00000000 && !pslverr)
    else $error("outputs not quiet after reset");
  AST_UNMAPPED: assert property (psel && penable && paddr >= 8'h20 |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_IDLE_NOERR: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
  AST_HOLD: assert property (!$stable(prdata) |-> $past(psel) && !$past(penable))
    else $error("read data moved outside setup");
  AST_NOT_PRESENT: assert property (acRd && paddr >= sddc_pkg::ADDR_BASE && !hiSh_r[15]
    |-> prdata == 32'h00000000) else $error("base or limit used while absent");
  AST_LIMIT: assert property (acRd && paddr == sddc_pkg::ADDR_LIMIT && hiSh_r[15]
    |-> prdata == limSh) else $error("effective limit wrong");
  AST_BASE: assert property (acRd && paddr == sddc_pkg::ADDR_BASE && hiSh_r[15]
    |-> prdata == {hiSh_r[31:24], hiSh_r[7:0], loSh_r[31:16]}) else $error("base wrong");
  AST_OPSIZE_CODE: assert property (stRd && prdata[5] |-> prdata[2])
    else $error("operand size outside code");
  AST_OPSIZE: assert property (stRd && prdata[9] && hiSh_r[12] && hiSh_r[11]
    |-> prdata[5] == hiSh_r[22]) else $error("operand size wrong");
  AST_NP_VECTOR: assert property (stRd && prdata[9] && hiSh_r[12] && !hiSh_r[15]
    |-> prdata[8] && prdata[23:16] == sddc_pkg::VEC_NOT_PRESENT) else $error("absent no fault");
  AST_LOCAL_PRIV: assert property (stRd && prdata[4] |-> prdata[11:10] == 2'b00)
    else $error("local table privilege not ignored");
  AST_KIND: assert property (stRd && prdata[9] |-> prdata[1] == hiSh_r[12])
    else $error("kind bit wrong");
  cover property (stRd && prdata[8]);
  cover property (stRd && prdata[3]);
  cover property (psel && penable && pslverr);
endmodule // sddc_check_chk
bind sddc_check_top sddc_check_chk sddc_check_chk_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
);
`default_nettype wire

// file: testbench/sddc_check_top_tb.sv
// self-checking bench: random descriptors against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module sddc_check_top_tb;
  logic        clk;        // 200 MHz core clock
  logic        sys_rst;    // synchronous reset
  logic        psel;       // apb select
  logic        penable;    // apb access phase
  logic        pwrite;     // apb direction
  logic [7:0]  paddr;      // apb address
  logic [31:0] pwdata;     // apb write data
  logic        pready;     // apb ready
  logic [31:0] prdata;     // apb read data
  logic        pslverr;    // apb error
  int          err_total;  // mismatches
  int          cmp_count;  // comparisons
  logic [31:0] lo, hi, off, q, expSt, expBase, expLim;  // stimulus and expectations
  logic [4:0]  ctl;        // control word
  logic [1:0]  acc;        // access kind
  logic        e;          // captured error flag
  sddc_check_top sddc_check_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic complete_run;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait for ready is bounded
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      $display("unexpected at %0t: no ready", $time);
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp);
    // only the aligned words up to the limit register answer without error
    chk({31'h0, e}, {31'h0, a[1:0] != 2'b00 || a > sddc_pkg::ADDR_LIMIT});
  endtask
  // page granular limits fill the low twelve bits with ones
  function automatic logic [31:0] effLim(input logic [31:0] l, input logic [31:0] h);
    return h[23] ? {h[19:16], l[15:0], 12'hFFF} : {12'h000, h[19:16], l[15:0]};
  endfunction
  // expected status word after a check
  function automatic logic [31:0] model(input logic [31:0] l, input logic [31:0] h,
      input logic [4:0] c, input logic [31:0] o, input logic [1:0] a);
    logic [7:0]  ar;
    logic [7:0]  v;
    logic        code;
    logic        lt;
    logic        bd;
    logic        f;
    logic [31:0] lm;
    ar = h[15:8];
    lm = effLim(l, h);
    code = ar[4] && ar[3];
    lt = !ar[4] && ar[3:0] == 4'h2;
    bd = !ar[4] && !(lt && c[2]);
    v = 8'h00;
    if (ar[4] && !ar[7]) v = 8'h0B;
    else if (!ar[4]) v = bd ? 8'h0D : (!ar[7] ? 8'h0B : (o > lm ? 8'h0D : 8'h00));
    else begin
      // odd access kinds are writes
      if (code) f = a[0] || (a == 2'd0 && !ar[1]) || (a == 2'd2 && ar[2] && c[1:0] < ar[6:5])
        || o > lm;
      else f = a == 2'd2 || (a[0] && !ar[1]) || c[1:0] > ar[6:5] || (ar[2] ? (o <= lm
        || o > (h[22] ? 32'hFFFFFFFF : 32'h0000FFFF)) : o > lm);
      if (f) v = 8'h0D;
    end
    return {8'h00, v, 4'h0, lt ? 2'b00 : ar[6:5], 1'b1, v != 8'h00, bd, ar[4] && !ar[3] && h[22],
      code && h[22], lt, !ar[4] && h[31:16] == 16'h0000, code, ar[4], ar[7]};
  endfunction
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    err_total = 0;
    cmp_count = 0;
    q = $urandom(23382);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // a cleared descriptor decodes as a legacy system one that is not usable,
    // so the status word shows the legacy and bad flags (bits 3 and 7)
    for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 5) ? 32'h00000088 : 32'h00000000);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    chk({31'h0, e}, 32'h00000001);
    rd(8'hFC, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    rd(sddc_pkg::ADDR_DESC_LO, 32'h00000000);
    for (int i = 0; i < 200; i++) begin
      lo = $urandom;
      hi = $urandom;
      ctl = 5'($urandom);
      acc = 2'($urandom);
      hi[21] = 1'b0;
      case ($urandom % 4)
        0: hi[31:16] = 16'h0000;
        1: hi[12:8] = 5'h02;
        2: hi[23:16] = 8'h00;
        default: ;
      endcase
      hi[15] = ($urandom % 6) != 0;
      if (hi[12] && !hi[11] && acc == 2'd3) hi[9] = 1'b1;
      if (hi[23] && {hi[19:16], lo[15:0]} == 20'hFFFFF) lo[27:16] = 12'h000;
      off = effLim(lo, hi) + 32'($urandom % 3) - 32'h00000001;
      if ($urandom % 4 == 0) off = $urandom;
      expSt = model(lo, hi, ctl, off, acc);
      expBase = hi[15] ? {hi[31:24], hi[7:0], lo[31:16]} : 32'h00000000;
      expLim = hi[15] ? effLim(lo, hi) : 32'h00000000;
      bus(1'b1, sddc_pkg::ADDR_DESC_LO, lo);
      bus(1'b1, sddc_pkg::ADDR_DESC_HI, hi);
      bus(1'b1, sddc_pkg::ADDR_CTRL, {27'h0, ctl});
      bus(1'b1, sddc_pkg::ADDR_OFFSET, off);
      bus(1'b1, sddc_pkg::ADDR_CHECK, {30'h0, acc});
      rd(sddc_pkg::ADDR_STATUS, expSt);
      rd(sddc_pkg::ADDR_BASE, expBase);
      rd(sddc_pkg::ADDR_LIMIT, expLim);
      if (hi[12] && (ctl[3] || ctl[4])) hi[8] = 1'b1;
      rd(sddc_pkg::ADDR_DESC_HI, hi);
      rd(sddc_pkg::ADDR_CTRL, {29'h0, ctl[2:0]});
    end
    // read-only registers ignore writes
    bus(1'b1, sddc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    bus(1'b1, sddc_pkg::ADDR_BASE, 32'hFFFFFFFF);
    bus(1'b1, sddc_pkg::ADDR_LIMIT, 32'hFFFFFFFF);
    rd(sddc_pkg::ADDR_STATUS, expSt);
    rd(sddc_pkg::ADDR_BASE, expBase);
    rd(sddc_pkg::ADDR_LIMIT, expLim);
    // a second reset in mid-run; descriptor high, status and offset read back their reset values
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(sddc_pkg::ADDR_DESC_HI, 32'h00000000);
    rd(sddc_pkg::ADDR_STATUS, 32'h00000088);
    rd(sddc_pkg::ADDR_OFFSET, 32'h00000000);
    complete_run();
  end
endmodule // sddc_check_top_tb
`default_nettype wire
